// File: testbench/sff_frame_port_sva.sv
// Assertions on the frame-format port
`timescale 1ns/1ns
`include "sff_defs.svh"

module sff_frame_port_sva
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Serial link
	input wire logic bitClk,
	input wire logic frameSync,
	input wire logic serialIn,
	input wire logic serialOut,
	input wire logic serialOutEn
);
	logic [31:0] txCopy;
	logic [31:0] rxCopy;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	//----
	// Expected register contents
	//----
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			txCopy <= '0;
			rxCopy <= '0;
		end
		else if (ack_o && we_i)
			for (int i = 0; i < 4; i++)
				if (sel_i[i] && adr_i == `SFF_OFS_TXFMT)
					txCopy[8*i +: 8] <= dat_i[8*i +: 8];
				else if (sel_i[i] && adr_i == `SFF_OFS_RXFMT)
					rxCopy[8*i +: 8] <= dat_i[8*i +: 8];

	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_rd(logic [7:0] a);
		ack_o && !we_i && adr_i == a;
	endsequence

	property p_ackAnswer;
		s_req |=> ack_o;
	endproperty
	a_ackAnswer: assert property (p_ackAnswer) else $error("no ack");
	property p_ackPulse;
		ack_o |=> !ack_o;
	endproperty
	a_ackPulse: assert property (p_ackPulse) else $error("long ack");
	property p_ackCause;
		ack_o |-> $past(cyc_i && stb_i);
	endproperty
	a_ackCause: assert property (p_ackCause) else $error("stray ack");
	property p_rsvZero;
		s_rd(`SFF_OFS_TXFMT) or s_rd(`SFF_OFS_RXFMT)
			|-> dat_o[15] == 1'b0 && dat_o[3:0] == 4'h0;
	endproperty
	a_rsvZero: assert property (p_rsvZero) else $error("rsv set");
	property p_txBack;
		s_rd(`SFF_OFS_TXFMT) |-> dat_o == (txCopy & `SFF_FMT_WMASK);
	endproperty
	a_txBack: assert property (p_txBack) else $error("tx fmt");
	property p_rxBack;
		s_rd(`SFF_OFS_RXFMT) |-> dat_o == (rxCopy & `SFF_FMT_WMASK);
	endproperty
	a_rxBack: assert property (p_rxBack) else $error("rx fmt");
	property p_quiet;
		$fell(rst) |-> !ack_o && !serialOutEn;
	endproperty
	a_quiet: assert property (p_quiet) else $error("busy at reset");
	property p_enHold;
		$rose(serialOutEn) |-> serialOutEn[*8];
	endproperty
	a_enHold: assert property (p_enHold) else $error("short word");
endmodule

bind sff_frame_port sff_frame_port_sva sff_frame_port_sva_i (.clk(clk),
	.rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.bitClk(bitClk), .frameSync(frameSync), .serialIn(serialIn),
	.serialOut(serialOut), .serialOutEn(serialOutEn));

// File: testbench/sff_link_partner.sv
// Serial peer: makes frames and captures the sent bits
`timescale 1ns/1ns

module sff_link_partner
(
	// Bench control
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] nBits,
	input wire logic [7:0] resyncAt,
	input wire logic [31:0] pattern,
	// Link
	output logic bitClk,
	output logic frameSync,
	output logic serialIn,
	input wire logic serialOut,
	input wire logic serialOutEn,
	// Capture
	output logic [31:0] word,
	output logic [7:0] count,
	output logic [7:0] lead,
	output logic done
);
	logic [31:0] sh;

	// Bit clock runs only inside frames; capture before the port reacts
	initial
	begin
		{bitClk, frameSync, serialIn, done, word, count, lead, sh} = '0;
		forever
		begin
			@(posedge go);
			#7;
			{word, count, lead} = '0;
			sh = pattern;
			for (int i = 0; i < nBits; i++)
			begin
				bitClk = 1'b1;
				// Sync period shows the inverse so a stale bit is caught
				if (i == 0)
					serialIn = ~sh[31];
				else
				begin
					serialIn = sh[31];
					sh = {sh[30:0], 1'b0};
				end
				frameSync = (i == 0) || (i == resyncAt);
				if (serialOutEn === 1'b1)
				begin
					if (count == 8'h00)
						lead = 8'(i);
					word = {word[30:0], serialOut};
					count++;
				end
				#80 bitClk = 1'b0;
				#80;
			end
			done = 1'b1;
			#20 done = 1'b0;
		end
	end
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the frame-format port
`timescale 1ns/1ns
`include "sff_defs.svh"

module testbench;
	logic clk, rst, cyc_i, stb_i, we_i, ack_o, go, done;
	logic bitClk, frameSync, serialIn, serialOut, serialOutEn;
	logic [7:0] adr_i, nBits, resyncAt, count, lead;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, word, v, pat, x, fmt;
	logic [31:0] expQ[$];
	logic [48:0] expS[$];
	logic [48:0] e;
	int fail_count, num_checks, seed, wl[6], b;

	sff_frame_port sff_frame_port_i (.clk(clk), .rst(rst), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .bitClk(bitClk),
		.frameSync(frameSync), .serialIn(serialIn), .serialOut(serialOut),
		.serialOutEn(serialOutEn));
	sff_link_partner sff_link_partner_i (.clk(clk), .go(go), .nBits(nBits),
		.resyncAt(resyncAt), .pattern(pat), .bitClk(bitClk),
		.frameSync(frameSync),
		.serialIn(serialIn), .serialOut(serialOut),
		.serialOutEn(serialOutEn), .word(word), .count(count),
		.lead(lead), .done(done));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] x);
		num_checks++;
		if (s !== x)
		begin
			$display("wrong value %s expected %h seen %h", n, x, s);
			fail_count++;
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		{cyc_i, stb_i, sel_i} <= 6'h3F;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack_o !== 1'b1 && n < 50);
		{cyc_i, stb_i, we_i} <= 3'h0;
		if (n >= 50)
		begin
			fail_count++;
			report_and_stop();
		end
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		expQ.push_back(x);
		wb(1'b0, a, 32'h0);
	endtask

	function automatic logic [31:0] fw(input logic dual,
		input logic [2:0] b2, input logic [1:0] c, input logic ig,
		input logic [1:0] dl, input logic [2:0] b1);
		return {dual, 7'h00, b2, c, ig, dl, 1'b0, 7'h00, b1, 5'h00};
	endfunction

	task automatic frame(input logic [31:0] f, input logic [31:0] d,
		input logic [7:0] nb, input logic [7:0] rs, input logic [48:0] x);
		int n;
		wb(1'b1, `SFF_OFS_TXFMT, f);
		wb(1'b1, `SFF_OFS_TXDATA, d);
		wb(1'b1, `SFF_OFS_CTRL, 32'h3);
		nBits <= nb;
		resyncAt <= rs;
		expS.push_back(x);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (n = 0; done !== 1'b1 && n < 2000; n++)
			@(posedge clk);
		if (n >= 2000)
		begin
			fail_count++;
			report_and_stop();
		end
		wb(1'b1, `SFF_OFS_CTRL, 32'h0);
	endtask

	//----
	// Result watchers
	//----
	always @(posedge clk)
		if (ack_o === 1'b1 && cyc_i && !we_i)
			check("read", dat_o, expQ.pop_front());

	always @(posedge done)
	begin
		e = expS.pop_front();
		check("lead", {24'h0, lead}, {24'h0, e[47:40]});
		if (e[39:32] == 8'hFF)
			check("restart", {31'h0, count > 8'h08}, 32'h1);
		else
			check("count", {24'h0, count}, {24'h0, e[39:32]});
		if (e[48])
			check("word", word, e[31:0]);
	end

	//----
	// Main sequence
	//----
	initial
	begin
		seed = 32'h50e9;
		wl = '{8, 12, 16, 20, 24, 32};
		{cyc_i, stb_i, we_i, go, adr_i, sel_i, dat_i} = '0;
		{nBits, resyncAt, pat} = '0;
		rst = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`SFF_OFS_RXFMT, `SFF_FMT_RST);
		rd(`SFF_OFS_TXFMT, `SFF_FMT_RST);
		for (int i = 0; i < 4; i++)
		begin
			v = $random(seed);
			wb(1'b1, `SFF_OFS_RXFMT, v);
			wb(1'b1, `SFF_OFS_TXFMT, ~v);
			wb(1'b1, 8'h20, v);
			rd(`SFF_OFS_RXFMT, v & `SFF_FMT_WMASK);
			rd(`SFF_OFS_TXFMT, ~v & `SFF_FMT_WMASK);
			rd(8'h20, 32'h0);
		end
		for (int c = 0; c < 6; c++)
		begin
			v = $random(seed);
			frame(fw(1'b0, 3'h5, 2'h0, 1'b0, 2'h0, c[2:0]), v, 8'(wl[c] + 4),
				8'h00, {1'b1, 8'h02, 8'(wl[c]),
				wl[c] == 32 ? v : v & ((32'h1 << wl[c]) - 32'h1)});
			frame(fw(1'b1, c[2:0], 2'h0, 1'b0, 2'h0, 3'h0), v,
				8'(wl[c] + 12), 8'h00,
				{1'b0, 8'h02, 8'(wl[c] + 8), 32'h0});
		end
		frame(fw(1'b0, 3'h0, 2'h1, 1'b0, 2'h0, 3'h0), 32'h96, 8'h0C, 8'h00,
			{1'b1, 8'h02, 8'h08, 32'h69});
		for (int k = 1; k < 4; k++)
			frame(fw(1'b0, 3'h0, k[1:0], 1'b0, 2'h0, 3'h1), 32'hA5C, 8'h10,
				8'h00, {1'b1, 8'h02, 8'h0C, 32'hA5C});
		for (int d = 1; d < 3; d++)
			frame(fw(1'b0, 3'h0, 2'h0, 1'b0, d[1:0], 3'h0), 32'h3C, 8'h0E,
				8'h00, {1'b1, 8'(2 + d), 8'h08, 32'h3C});
		// Mu-law then A-law of zero and of full positive scale
		for (int k = 0; k < 4; k++)
			frame(fw(1'b0, 3'h0, {1'b1, k[1]}, 1'b0, 2'h0, 3'h0),
				k[0] ? 32'h7FFF : 32'h0, 8'h0C, 8'h00, {1'b1, 8'h02, 8'h08,
				k == 0 ? 32'hFF : k == 1 ? 32'h80 : k == 2 ? 32'hD5 :
				32'hAA});
		// Receive every word length, last pass with 32-bit reversal
		for (int c = 0; c < 7; c++)
		begin
			b = (c > 4) ? 5 : c;
			v = $random(seed);
			for (int j = 0; j < 32; j++)
				x[j] = v[31 - j];
			fmt = fw(1'b0, 3'h0, {1'b0, c == 6}, 1'b0, 2'h0, 3'(b)) |
				((c == 6) ? 32'h10 : 32'h0);
			pat <= v;
			wb(1'b1, `SFF_OFS_RXFMT, fmt);
			frame(fmt, v, 8'(wl[b] + 4), 8'h00,
				{c == 6, 8'h02, 8'(wl[b]), x});
			rd(`SFF_OFS_RXDATA,
				(c == 6) ? x : v >> (32 - wl[b]));
		end
		frame(fw(1'b0, 3'h0, 2'h0, 1'b1, 2'h0, 3'h0), 32'hC3, 8'h14, 8'h05,
			{1'b1, 8'h02, 8'h08, 32'hC3});
		frame(fw(1'b0, 3'h0, 2'h0, 1'b0, 2'h0, 3'h0), 32'hC3, 8'h14, 8'h05,
			{1'b0, 8'h02, 8'hFF, 32'h0});
		report_and_stop();
	end
endmodule

// File: verilog/sff_defs.svh
// Offsets, field codes and reset values of the frame-format block
//----------------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------------
// Overview of operation
// RULE_01: Transmit phases bit picks single or dual frame
// RULE_02: Receive phase-one length N gives N+1 words
// RULE_03: Receive word code 0-5 means 8..32 bits
// RULE_04: Transmit phase-two word code 0-5 means 8..32 bits
// RULE_05: Receive reversal takes 32-bit words LSB first
// RULE_06: Transmit compand: MSB, LSB-first, mu-law, A-law
// RULE_07: Nonzero compand acts only for 8-bit words
// RULE_08: Frame ignore bit drops later syncs mid-frame
// RULE_09: Transmit delay code 0-2 delays first bit
// RULE_10: Reserved bits read zero, writes ignored
// RULE_11: Transmit control word keeps the fixed field layout
// RULE_12: Single-phase frames use phase-one settings only
`ifndef SFF_DEFS_SVH
`define SFF_DEFS_SVH

//----------------------------------------------------------------------
// Register byte offsets
//----------------------------------------------------------------------
`define SFF_OFS_RXFMT 8'h00
`define SFF_OFS_TXFMT 8'h04
`define SFF_OFS_TXDATA 8'h08
`define SFF_OFS_RXDATA 8'h0C
`define SFF_OFS_STATUS 8'h10
`define SFF_OFS_CTRL 8'h14

//----------------------------------------------------------------------
// Field codes and reset values
//----------------------------------------------------------------------
`define SFF_FMT_WMASK 32'hFFFF7FF0
`define SFF_FMT_RST 32'h00000000
`define SFF_BITS_8 3'h0
`define SFF_BITS_12 3'h1
`define SFF_BITS_16 3'h2
`define SFF_BITS_20 3'h3
`define SFF_BITS_24 3'h4
`define SFF_BITS_32 3'h5
`define SFF_CMP_MSB 2'h0
`define SFF_CMP_LSB 2'h1
`define SFF_CMP_MU 2'h2
`define SFF_CMP_A 2'h3
`define SFF_DLY_NONE 2'h0

//----------------------------------------------------------------------
// Status and control bit positions
//----------------------------------------------------------------------
`define SFF_ST_TXEMPTY 0
`define SFF_ST_RXFULL 1
`define SFF_ST_TXUNDER 2
`define SFF_ST_RXOVER 3
`define SFF_CT_TXEN 0
`define SFF_CT_RXEN 1

`endif

// File: verilog/sff_frame_port.sv
// Serial frame-format port with classic Wishbone register access
`timescale 1ns/1ns
`include "sff_defs.svh"

module sff_frame_port
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Serial link
	input wire logic bitClk,
	input wire logic frameSync,
	input wire logic serialIn,
	output logic serialOut,
	output logic serialOutEn
);

	//------------------------------------------------------------------
	// Helper functions
	//------------------------------------------------------------------
	function automatic logic [5:0] wordBits(input logic [2:0] code);
		case (code)
			`SFF_BITS_8: wordBits = 6'h08;
			`SFF_BITS_12: wordBits = 6'h0C;
			`SFF_BITS_16: wordBits = 6'h10;
			`SFF_BITS_20: wordBits = 6'h14;
			`SFF_BITS_24: wordBits = 6'h18;
			`SFF_BITS_32: wordBits = 6'h20;
			default: wordBits = 6'h08;
		endcase
	endfunction

	function automatic logic [31:0] rev32(input logic [31:0] d);
		logic [31:0] r;
		r = 32'h00000000;
		for (int i = 0; i < 32; i++)
			r[i] = d[31 - i];
		rev32 = r;
	endfunction

	// Linear 16-bit sample to mu-law or A-law byte
	function automatic logic [7:0] compress(input logic [15:0] s,
		input logic aLaw);
		logic sign;
		logic [15:0] mag;
		logic [2:0] seg;
		logic [3:0] mant;
		sign = s[15];
		mag = sign ? 16'(~s + 16'h0001) : s;
		seg = 3'h0;
		if (aLaw)
		begin
			mag = mag >> 3;
			for (int i = 5; i < 12; i++)
				if (mag[i])
					seg = 3'(i - 4);
			mant = (seg == 3'h0) ? mag[4:1] : 4'(mag >> seg);
			compress = {~sign, seg, mant} ^ 8'h55;
		end
		else
		begin
			mag = mag >> 2;
			if (mag > 16'h1FDE)
				mag = 16'h1FDE;
			mag = mag + 16'h0021;
			for (int i = 6; i < 13; i++)
				if (mag[i])
					seg = 3'(i - 5);
			mant = 4'(mag >> (seg + 3'h1));
			compress = ~{sign, seg, mant};
		end
	endfunction

	//------------------------------------------------------------------
	// Pin synchronisers and edge detect
	//------------------------------------------------------------------
	sff_pkg::sff_pins_t pinMeta;
	sff_pkg::sff_pins_t pinSync;
	sff_pkg::sff_pins_t pinLast;
	logic bclkRise;
	logic bclkFall;
	logic fsRise;
	logic fsLastFall;

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			pinMeta <= '0;
			pinSync <= '0;
			pinLast <= '0;
		end
		else
		begin
			pinMeta <= {bitClk, frameSync, serialIn};
			pinSync <= pinMeta;
			pinLast <= pinSync;
		end

	assign bclkRise = pinSync.bclk & ~pinLast.bclk;
	assign bclkFall = ~pinSync.bclk & pinLast.bclk;

	// Frame sync is sampled on falling bit clock edges
	always_ff @(posedge clk or posedge rst)
		if (rst)
			fsLastFall <= 1'b0;
		else if (bclkFall)
			fsLastFall <= pinSync.fsync;

	assign fsRise = bclkFall & pinSync.fsync & ~fsLastFall;

	//------------------------------------------------------------------
	// Registers and Wishbone slave
	//------------------------------------------------------------------
	logic [31:0] rxFmtReg;
	logic [31:0] txFmtReg;
	sff_pkg::sff_fmt_t rxFmt;
	sff_pkg::sff_fmt_t txFmt;
	logic [31:0] txHold;
	logic [31:0] rxWord;
	logic [1:0] ctrl;
	logic txEmpty;
	logic rxFull;
	logic txUnder;
	logic rxOver;
	logic busReq;
	logic busWr;
	logic [31:0] wmask;
	logic [31:0] status;
	logic txLoad;
	logic rxDone;

	assign rxFmt = sff_pkg::sff_fmt_t'(rxFmtReg);
	assign txFmt = sff_pkg::sff_fmt_t'(txFmtReg);
	assign busReq = cyc_i & stb_i & ~ack_o;
	assign busWr = busReq & we_i;
	assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
		{8{sel_i[0]}}};
	assign status = {28'h0000000, rxOver, txUnder, rxFull, txEmpty};

	always_ff @(posedge clk or posedge rst)
		if (rst)
			ack_o <= 1'b0;
		else
			ack_o <= busReq;

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			rxFmtReg <= `SFF_FMT_RST;
			txFmtReg <= `SFF_FMT_RST;
			ctrl <= 2'h0;
		end
		else if (busWr)
		begin
			if (adr_i == `SFF_OFS_RXFMT)
				rxFmtReg <= (rxFmtReg & ~(wmask & `SFF_FMT_WMASK)) |
					(dat_i & wmask & `SFF_FMT_WMASK); // RULE_10 RULE_02
			if (adr_i == `SFF_OFS_TXFMT)
				txFmtReg <= (txFmtReg & ~(wmask & `SFF_FMT_WMASK)) |
					(dat_i & wmask & `SFF_FMT_WMASK); // RULE_10 RULE_11
			if (adr_i == `SFF_OFS_CTRL && sel_i[0])
				ctrl <= dat_i[1:0];
		end

	always_ff @(posedge clk or posedge rst)
		if (rst)
			dat_o <= 32'h00000000;
		else if (busReq && !we_i)
			case (adr_i)
				`SFF_OFS_RXFMT: dat_o <= rxFmtReg & `SFF_FMT_WMASK; // RULE_10
				`SFF_OFS_TXFMT: dat_o <= txFmtReg & `SFF_FMT_WMASK; // RULE_10
				`SFF_OFS_RXDATA: dat_o <= rxWord;
				`SFF_OFS_STATUS: dat_o <= status;
				`SFF_OFS_CTRL: dat_o <= {30'h00000000, ctrl};
				default: dat_o <= 32'h00000000;
			endcase

	// Transmit holding word; a word load wins over a same-cycle write
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			txHold <= 32'h00000000;
			txEmpty <= 1'b1;
		end
		else
		begin
			if (busWr && adr_i == `SFF_OFS_TXDATA)
			begin
				txHold <= (txHold & ~wmask) | (dat_i & wmask);
				txEmpty <= 1'b0;
			end
			if (txLoad)
				txEmpty <= 1'b1;
		end

	// Sticky flags; hardware set wins over software clear
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			rxFull <= 1'b0;
			txUnder <= 1'b0;
			rxOver <= 1'b0;
		end
		else
		begin
			if (busReq && !we_i && adr_i == `SFF_OFS_RXDATA)
				rxFull <= 1'b0;
			if (busWr && adr_i == `SFF_OFS_STATUS && sel_i[0])
			begin
				if (dat_i[`SFF_ST_TXUNDER])
					txUnder <= 1'b0;
				if (dat_i[`SFF_ST_RXOVER])
					rxOver <= 1'b0;
			end
			if (rxDone)
			begin
				rxFull <= 1'b1;
				if (rxFull)
					rxOver <= 1'b1;
			end
			if (txLoad && txEmpty)
				txUnder <= 1'b1;
		end

	//------------------------------------------------------------------
	// Transmit framing
	//------------------------------------------------------------------
	sff_pkg::sff_tx_state_t txState;
	logic startPend;
	logic txPhase2;
	logic [6:0] txWordCnt;
	logic [5:0] txBitCnt;
	logic [1:0] txDlyCnt;
	logic [31:0] txShift;
	logic txEnabled;
	logic doStart;
	logic usePhase2;
	logic [6:0] curLen;
	logic [2:0] curCode;
	logic lastInPhase;
	logic lastWord;
	logic wordDone;
	logic loadPhase2;
	logic [2:0] loadCode;
	logic [1:0] loadMode;
	logic [5:0] loadBits;
	logic [31:0] loadSrc;
	logic [31:0] loadWord;

	assign txEnabled = ctrl[`SFF_CT_TXEN];
	assign usePhase2 = txPhase2 & txFmt.dual; // RULE_12
	assign curLen = usePhase2 ? txFmt.len2 : txFmt.len1; // RULE_01 RULE_12
	assign curCode = usePhase2 ? txFmt.bits2 : txFmt.bits1; // RULE_04
	assign lastInPhase = (txWordCnt == curLen);
	assign lastWord = lastInPhase & (usePhase2 | ~txFmt.dual); // RULE_01
	assign wordDone = (txState == sff_pkg::TX_SHIFT) &&
		(txBitCnt == wordBits(curCode));
	// Later syncs restart the frame unless ignored mid-frame
	assign doStart = bclkRise & startPend & txEnabled &
		((txState == sff_pkg::TX_IDLE) | ~txFmt.syncIgnore); // RULE_08
	assign txLoad = bclkRise & ((doStart & (txFmt.delay == `SFF_DLY_NONE)) |
		(~doStart & (txState == sff_pkg::TX_DELAY) & (txDlyCnt == 2'h0)) |
		(~doStart & wordDone & ~lastWord)); // RULE_09

	always_comb
	begin
		if (doStart || txState == sff_pkg::TX_DELAY)
			loadPhase2 = 1'b0;
		else
			loadPhase2 = (lastInPhase | txPhase2) & txFmt.dual; // RULE_01
		loadCode = loadPhase2 ? txFmt.bits2 : txFmt.bits1; // RULE_12
		loadBits = wordBits(loadCode);
		// Companding only for 8-bit words
		loadMode = (loadCode == `SFF_BITS_8) ? txFmt.compand :
			`SFF_CMP_MSB; // RULE_07
		loadSrc = txEmpty ? 32'h00000000 : txHold;
		case (loadMode) // RULE_06
			`SFF_CMP_LSB: loadWord = rev32(loadSrc);
			`SFF_CMP_MU: loadWord = {compress(loadSrc[15:0], 1'b0), 24'h000000};
			`SFF_CMP_A: loadWord = {compress(loadSrc[15:0], 1'b1), 24'h000000};
			default: loadWord = loadSrc << (6'h20 - loadBits);
		endcase
		if (txFmt.bitReverse && loadCode == `SFF_BITS_32)
			loadWord = rev32(loadSrc);
	end

	always_ff @(posedge clk or posedge rst)
		if (rst)
			startPend <= 1'b0;
		else if (fsRise)
			startPend <= 1'b1;
		else if (bclkRise)
			startPend <= 1'b0;

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			txState <= sff_pkg::TX_IDLE;
			txPhase2 <= 1'b0;
			txWordCnt <= 7'h00;
			txDlyCnt <= 2'h0;
		end
		else if (!txEnabled)
			txState <= sff_pkg::TX_IDLE;
		else if (doStart)
		begin
			txPhase2 <= 1'b0;
			txWordCnt <= 7'h00;
			txDlyCnt <= 2'(txFmt.delay - 2'h1); // RULE_09
			txState <= (txFmt.delay == `SFF_DLY_NONE) ? sff_pkg::TX_SHIFT :
				sff_pkg::TX_DELAY;
		end
		else if (bclkRise)
			case (txState)
				sff_pkg::TX_DELAY:
					if (txDlyCnt == 2'h0)
						txState <= sff_pkg::TX_SHIFT;
					else
						txDlyCnt <= txDlyCnt - 2'h1;
				sff_pkg::TX_SHIFT:
					if (wordDone)
					begin
						if (lastWord)
							txState <= sff_pkg::TX_IDLE;
						else if (lastInPhase)
						begin
							txPhase2 <= 1'b1;
							txWordCnt <= 7'h00;
						end
						else
							txWordCnt <= txWordCnt + 7'h01;
					end
				default:
					txState <= sff_pkg::TX_IDLE;
			endcase

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			txShift <= 32'h00000000;
			txBitCnt <= 6'h00;
			serialOut <= 1'b0;
			serialOutEn <= 1'b0;
		end
		else if (txLoad)
		begin
			serialOut <= loadWord[31];
			txShift <= {loadWord[30:0], 1'b0};
			txBitCnt <= 6'h01;
			serialOutEn <= 1'b1;
		end
		else if (bclkRise)
		begin
			if (wordDone || txState != sff_pkg::TX_SHIFT || !txEnabled)
			begin
				serialOutEn <= 1'b0;
				serialOut <= 1'b0;
			end
			else
			begin
				serialOut <= txShift[31];
				txShift <= {txShift[30:0], 1'b0};
				txBitCnt <= txBitCnt + 6'h01;
			end
		end

	//------------------------------------------------------------------
	// Receive framing, phase-one settings
	//------------------------------------------------------------------
	logic rxActive;
	logic [1:0] rxDlyCnt;
	logic [6:0] rxWordCnt;
	logic [5:0] rxBitCnt;
	logic [31:0] rxShift;
	logic [5:0] rxBits;
	logic rxSample;

	assign rxBits = wordBits(rxFmt.bits1); // RULE_03
	assign rxSample = bclkFall & rxActive & ~fsRise & (rxDlyCnt == 2'h0);
	assign rxDone = rxSample & (rxBitCnt == rxBits - 6'h01);

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			rxActive <= 1'b0;
			rxDlyCnt <= 2'h0;
			rxWordCnt <= 7'h00;
			rxBitCnt <= 6'h00;
			rxShift <= 32'h00000000;
		end
		else if (!ctrl[`SFF_CT_RXEN])
			rxActive <= 1'b0;
		else if (fsRise && (!rxActive || !rxFmt.syncIgnore))
		begin
			rxActive <= 1'b1;
			rxDlyCnt <= rxFmt.delay;
			rxWordCnt <= 7'h00;
			rxBitCnt <= 6'h00;
		end
		else if (bclkFall && rxActive && rxDlyCnt != 2'h0)
			rxDlyCnt <= rxDlyCnt - 2'h1;
		else if (rxSample)
		begin
			rxShift <= {rxShift[30:0], pinSync.din};
			rxBitCnt <= rxDone ? 6'h00 : rxBitCnt + 6'h01;
			if (rxDone)
			begin
				rxWordCnt <= rxWordCnt + 7'h01;
				if (rxWordCnt == rxFmt.len1) // RULE_02
					rxActive <= 1'b0;
			end
		end

	always_ff @(posedge clk or posedge rst)
		if (rst)
			rxWord <= 32'h00000000;
		else if (rxDone)
		begin
			if (rxFmt.bitReverse && rxFmt.bits1 == `SFF_BITS_32)
				rxWord <= rev32({rxShift[30:0], pinSync.din}); // RULE_05
			else
				rxWord <= {rxShift[30:0], pinSync.din} &
					(32'hFFFFFFFF >> (6'h20 - rxBits)); // RULE_03
		end

endmodule

// File: verilog/sff_pkg.sv
// Types shared by the frame-format block
package sff_pkg;

	// Control word layout, same for transmit and receive
	typedef struct packed {
		logic dual;
		logic [6:0] len2;
		logic [2:0] bits2;
		logic [1:0] compand;
		logic syncIgnore;
		logic [1:0] delay;
		logic rsv15;
		logic [6:0] len1;
		logic [2:0] bits1;
		logic bitReverse;
		logic [3:0] rsvLow;
	} sff_fmt_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h1,
		TX_DELAY = 3'h2,
		TX_SHIFT = 3'h4
	} sff_tx_state_t;

	typedef struct packed {
		logic bclk;
		logic fsync;
		logic din;
	} sff_pins_t;

endpackage
